// ### core/fcs_pkg.sv
package fcs_pkg;

	// ----------------------------------------
	// Register map (index, byte address = 4 * index)
	// ----------------------------------------
	localparam logic [11:0] FCS_IDX_CTRL = 12'h000;
	localparam logic [11:0] FCS_IDX_MODE = 12'h001;
	localparam logic [11:0] FCS_IDX_STAT = 12'h002;
	localparam logic [11:0] FCS_ADDR_CTRL = FCS_IDX_CTRL << 2;
	localparam logic [11:0] FCS_ADDR_MODE = FCS_IDX_MODE << 2;
	localparam logic [11:0] FCS_ADDR_STAT = FCS_IDX_STAT << 2;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int FCS_CTRL_RST_BIT = 7;
	localparam int FCS_CTRL_IRQEN_BIT = 1;
	localparam int FCS_CTRL_EN_BIT = 0;
	localparam int FCS_MODE_POS = 4;
	localparam int FCS_REGION_POS = 0;
	localparam int FCS_STAT_OK_BIT = 1;
	localparam int FCS_STAT_BUSY_BIT = 0;
	localparam logic [7:0] FCS_STAT_RESET = 8'h02;
	localparam logic [1:0] FCS_MODE_PRIORITY = 2'h0;

	localparam logic [1:0] FCS_REGION_FULL = 2'h0;
	localparam logic [1:0] FCS_REGION_BOOT_PLUS_APP_REGION = 2'h1;
	localparam logic [1:0] FCS_REGION_BOOT = 2'h2;

	// ----------------------------------------
	// Checksum and timing
	// ----------------------------------------
	localparam logic [15:0] FCS_CRC_POLY = 16'h1021;
	localparam logic [15:0] FCS_CRC_INIT = 16'hffff;
	localparam logic [1:0] FCS_START_DELAY = 2'h3;
	localparam int FCS_FETCH_PERIOD = 3;
	localparam logic [16:0] FCS_FLASH_LAST = 17'h07fff;
	localparam logic [7:0] FCS_FUSE_SCALE_PAD = 8'h00;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [4:0] {
		FCS_S_IDLE = 5'h01,
		FCS_S_DELAY = 5'h02,
		FCS_S_REQ = 5'h04,
		FCS_S_LO = 5'h08,
		FCS_S_HI = 5'h10
	} fcs_fsm_t;

	typedef struct packed {
		logic scan_en;
		logic [1:0] region;
		logic [7:0] boot_end;
		logic [7:0] app_end;
	} fcs_fuse_t;

	typedef struct packed {
		fcs_fsm_t fsm;
		logic [1:0] delay_cnt;
		logic enable;
		logic irq_en;
		logic [1:0] region;
		logic [1:0] mode;
		logic ok;
		logic nmi;
		logic [15:0] crc;
		logic [14:0] word_addr;
		logic [14:0] last_word;
		logic [7:0] data_hi;
		logic flash_req;
		logic cpu_stall;
		logic cpu_run;
		logic boot_done;
		logic irq_defer;
		logic slept;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} fcs_state_t;

endpackage : fcs_pkg

// ### core/fcs_scanner.sv
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module fcs_scanner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire fcs_pkg::fcs_fuse_t fuse,
	input wire logic cpu_sleep,
	output logic flash_req,
	output logic [14:0] flash_addr,
	input wire logic [15:0] flash_rdata,
	output logic cpu_stall,
	output logic cpu_run,
	output logic irq_defer,
	output logic nmi_req
);

	// ----------------------------------------
	// Checksum step over one byte
	// ----------------------------------------
	function automatic logic [15:0] fcs_crc_byte(
		input logic [15:0] c,
		input logic [7:0] d
	);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 7; i >= 0; i--)
		begin
			fb = r[15] ^ d[i];
			r = {r[14:0], 1'b0} ^ (fb ? fcs_pkg::FCS_CRC_POLY : 16'h0000);
		end
		return r;
	endfunction : fcs_crc_byte

	// Last word index of the region; reserved code is taken as full flash
	function automatic logic [14:0] fcs_last_word(
		input logic [1:0] region,
		input fcs_pkg::fcs_fuse_t f
	);
		logic [16:0] end_b;
		unique case (region)
			fcs_pkg::FCS_REGION_BOOT:
				end_b = {1'b0, f.boot_end, fcs_pkg::FCS_FUSE_SCALE_PAD};
			fcs_pkg::FCS_REGION_BOOT_PLUS_APP_REGION:
				end_b = {1'b0, f.app_end, fcs_pkg::FCS_FUSE_SCALE_PAD};
			default:
				end_b = fcs_pkg::FCS_FLASH_LAST + 17'h00001;
		endcase
		end_b = end_b - 17'h00001;
		return end_b[15:1];
	endfunction : fcs_last_word

	// ----------------------------------------
	// State
	// ----------------------------------------
	fcs_pkg::fcs_state_t s_r;
	fcs_pkg::fcs_state_t s_nxt;
	logic busy;
	logic apb_new;
	logic wr_commit;
	logic soft_rst;
	logic at_last;
	logic [15:0] crc_fin;
	logic pass;
	logic [31:0] rd_val;
	logic addr_hit;

	assign busy = s_r.fsm != fcs_pkg::FCS_S_IDLE;
	assign apb_new = psel & penable & ~s_r.pready;
	assign wr_commit = psel & penable & s_r.pready & pwrite & ~s_r.pslverr
		& ~s_r.nmi & s_r.boot_done;
	assign soft_rst = wr_commit & (paddr == fcs_pkg::FCS_ADDR_CTRL)
		& pwdata[fcs_pkg::FCS_CTRL_RST_BIT] & (~s_r.irq_en | ~busy);
	assign at_last = s_r.word_addr == s_r.last_word;
	assign crc_fin = fcs_crc_byte(s_r.crc, s_r.data_hi);
	assign pass = crc_fin == 16'h0000;

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	always_comb
	begin
		rd_val = 32'h00000000;
		addr_hit = 1'b1;
		unique case (paddr)
			fcs_pkg::FCS_ADDR_CTRL:
			begin
				rd_val[fcs_pkg::FCS_CTRL_IRQEN_BIT] = s_r.irq_en;
				rd_val[fcs_pkg::FCS_CTRL_EN_BIT] = s_r.enable;
			end
			fcs_pkg::FCS_ADDR_MODE:
			begin
				rd_val[fcs_pkg::FCS_MODE_POS +: 2] = s_r.mode;
				rd_val[fcs_pkg::FCS_REGION_POS +: 2] = s_r.region;
			end
			fcs_pkg::FCS_ADDR_STAT:
			begin
				rd_val[fcs_pkg::FCS_STAT_OK_BIT] = s_r.ok;
				rd_val[fcs_pkg::FCS_STAT_BUSY_BIT] = busy;
			end
			default:
				addr_hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.flash_req = 1'b0;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;

		// Bus slave: one wait cycle, write lands on the pready edge
		if (apb_new)
		begin
			s_nxt.pready = 1'b1;
			s_nxt.pslverr = ~addr_hit;
			s_nxt.prdata = rd_val;
		end

		// Reset-time scan, fuse caught on the first edge after release
		if (!s_r.boot_done)
		begin
			s_nxt.boot_done = 1'b1;
			if (fuse.scan_en)
			begin
				s_nxt.enable = 1'b1;
				s_nxt.region = fuse.region;
				s_nxt.crc = fcs_pkg::FCS_CRC_INIT;
				s_nxt.word_addr = 15'h0000;
				s_nxt.last_word = fcs_last_word(fuse.region, fuse);
				s_nxt.fsm = fcs_pkg::FCS_S_REQ;
				s_nxt.cpu_stall = 1'b1;
			end
			else
			begin
				s_nxt.cpu_run = 1'b1;
			end
		end

		// Register writes
		if (soft_rst)
		begin
			s_nxt.enable = 1'b0;
			s_nxt.region = 2'h0;
			s_nxt.mode = 2'h0;
			s_nxt.ok = fcs_pkg::FCS_STAT_RESET[fcs_pkg::FCS_STAT_OK_BIT];
			s_nxt.fsm = fcs_pkg::FCS_S_IDLE;
			s_nxt.cpu_stall = 1'b0;
			s_nxt.irq_defer = 1'b0;
			s_nxt.slept = 1'b0;
		end
		else if (wr_commit && !busy)
		begin
			if (paddr == fcs_pkg::FCS_ADDR_CTRL)
			begin
				if (pwdata[fcs_pkg::FCS_CTRL_IRQEN_BIT])
					s_nxt.irq_en = 1'b1;
				if (pwdata[fcs_pkg::FCS_CTRL_EN_BIT])
				begin
					s_nxt.enable = 1'b1;
					s_nxt.delay_cnt = 2'h0;
					s_nxt.fsm = fcs_pkg::FCS_S_DELAY;
				end
			end
			else if (paddr == fcs_pkg::FCS_ADDR_MODE)
			begin
				s_nxt.mode = pwdata[fcs_pkg::FCS_MODE_POS +: 2];
				s_nxt.region = pwdata[fcs_pkg::FCS_REGION_POS +: 2];
			end
		end

		// Scan engine; every mode code runs the priority scan
		if (!soft_rst)
		begin
			unique case (s_r.fsm)
				fcs_pkg::FCS_S_IDLE:
				begin
				end
				fcs_pkg::FCS_S_DELAY:
				begin
					if (cpu_sleep)
					begin
						s_nxt.slept = 1'b1;
						s_nxt.irq_defer = 1'b1;
					end
					else if (s_r.delay_cnt == fcs_pkg::FCS_START_DELAY - 2'h1)
					begin
						s_nxt.crc = fcs_pkg::FCS_CRC_INIT;
						s_nxt.word_addr = 15'h0000;
						s_nxt.last_word = fcs_last_word(s_r.region, fuse);
						s_nxt.cpu_stall = 1'b1;
						s_nxt.irq_defer = s_r.slept;
						s_nxt.fsm = fcs_pkg::FCS_S_REQ;
					end
					else
						s_nxt.delay_cnt = s_r.delay_cnt + 2'h1;
				end
				fcs_pkg::FCS_S_REQ:
				begin
					if (!cpu_sleep)
					begin
						s_nxt.flash_req = 1'b1;
						s_nxt.fsm = fcs_pkg::FCS_S_LO;
					end
				end
				fcs_pkg::FCS_S_LO:
				begin
					s_nxt.crc = fcs_crc_byte(s_r.crc, flash_rdata[7:0]);
					s_nxt.data_hi = flash_rdata[15:8];
					s_nxt.fsm = fcs_pkg::FCS_S_HI;
				end
				fcs_pkg::FCS_S_HI:
				begin
					s_nxt.crc = crc_fin;
					if (at_last)
					begin
						s_nxt.fsm = fcs_pkg::FCS_S_IDLE;
						s_nxt.cpu_stall = 1'b0;
						s_nxt.irq_defer = 1'b0;
						s_nxt.slept = 1'b0;
						s_nxt.ok = pass;
						if (!pass && s_r.irq_en)
							s_nxt.nmi = 1'b1;
						if (pass)
							s_nxt.cpu_run = 1'b1;
					end
					else
					begin
						s_nxt.word_addr = s_r.word_addr + 15'h0001;
						s_nxt.fsm = fcs_pkg::FCS_S_REQ;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r <= '0;
			s_r.fsm <= fcs_pkg::FCS_S_IDLE;
			s_r.ok <= fcs_pkg::FCS_STAT_RESET[fcs_pkg::FCS_STAT_OK_BIT];
			s_r.crc <= fcs_pkg::FCS_CRC_INIT;
		end
		else
			s_r <= s_nxt;
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign flash_req = s_r.flash_req;
	assign flash_addr = s_r.word_addr;
	assign cpu_stall = s_r.cpu_stall;
	assign cpu_run = s_r.cpu_run;
	assign irq_defer = s_r.irq_defer;
	assign nmi_req = s_r.nmi;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking fcs_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_nmi_stays_up: assert property (nmi_req |=> nmi_req)
		else $error("failure interrupt dropped");

	a_irq_en_sticky: assert property (s_r.irq_en |=> s_r.irq_en)
		else $error("interrupt enable cleared without reset");

	a_start_three: assert property (
		$rose(s_r.fsm == fcs_pkg::FCS_S_DELAY) && !cpu_sleep
		##1 !cpu_sleep ##1 !cpu_sleep |=> s_r.fsm == fcs_pkg::FCS_S_REQ)
		else $error("scan did not start three cycles after enable");

	a_cpu_runs_delay: assert property (
		s_r.fsm == fcs_pkg::FCS_S_DELAY |-> !cpu_stall)
		else $error("processor stalled during start delay");

	a_fetch_spacing: assert property (
		flash_req |=> !flash_req ##1 !flash_req)
		else $error("flash fetched faster than every third cycle");

	a_crc_preset: assert property (
		s_r.fsm == fcs_pkg::FCS_S_REQ && $past(s_r.fsm) == fcs_pkg::FCS_S_DELAY
		|-> s_r.crc == fcs_pkg::FCS_CRC_INIT && s_r.word_addr == 15'h0000)
		else $error("scan began without checksum preset");

	a_stall_scan: assert property (
		s_r.fsm inside {fcs_pkg::FCS_S_LO, fcs_pkg::FCS_S_HI} |-> cpu_stall)
		else $error("processor not stalled during scan");

	a_fail_raises: assert property (
		$fell(s_r.ok) && s_r.irq_en |-> nmi_req)
		else $error("failure did not raise interrupt");

	a_pass_result: assert property (
		s_r.fsm == fcs_pkg::FCS_S_HI && at_last && !soft_rst
		|=> s_r.ok == $past(pass) && !busy)
		else $error("pass flag does not match remainder");

	a_mode_locked: assert property (
		busy && wr_commit && paddr == fcs_pkg::FCS_ADDR_MODE && !soft_rst
		|=> $stable(s_r.region) && $stable(s_r.mode))
		else $error("region changed during a scan");

	a_sleep_holds: assert property (
		s_r.fsm == fcs_pkg::FCS_S_DELAY && cpu_sleep
		|=> s_r.fsm == fcs_pkg::FCS_S_DELAY && irq_defer)
		else $error("scan started while asleep");

	a_defer_idle: assert property (!busy |-> !irq_defer)
		else $error("handlers held with no scan running");

	a_sleep_pause: assert property (
		s_r.fsm == fcs_pkg::FCS_S_REQ && cpu_sleep |=> !flash_req)
		else $error("flash fetched while asleep");

	a_run_on_pass: assert property ($rose(cpu_run) |-> s_r.ok)
		else $error("processor released without a passing check");

	c_scan_pass: cover property (
		s_r.fsm == fcs_pkg::FCS_S_HI && at_last && pass);
	c_scan_fail_nmi: cover property ($rose(nmi_req));
	c_sleep_delay: cover property (
		s_r.fsm == fcs_pkg::FCS_S_DELAY && cpu_sleep);
	c_boot_scan: cover property ($rose(cpu_run) && s_r.enable);

endmodule : fcs_scanner

// ### test/fcs_flash_model.sv
`timescale 1ns/100ps
module fcs_flash_model #(
	parameter int WORDS = 128
) (
	input wire logic flash_req,
	input wire logic [14:0] flash_addr,
	input wire logic corrupt,
	output logic [15:0] flash_rdata
);
	logic [7:0] mem [2*WORDS];
	logic [15:0] crc;
	logic [7:0] lo;

	// ----------------------------------------
	// Region image, checksum in its last two bytes
	// ----------------------------------------
	initial
	begin
		crc = 16'hffff;
		for (int i = 0; i < 2*WORDS-2; i++)
		begin
			mem[i] = 8'(i) ^ 8'ha5;
			for (int b = 7; b >= 0; b--)
				crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ mem[i][b]) ? 16'h1021 : 16'h0);
		end
		mem[2*WORDS-2] = crc[15:8];
		mem[2*WORDS-1] = crc[7:0];
	end

	// Word shown while the request stands, inverted otherwise
	assign lo = mem[{flash_addr[6:0], 1'b0}] ^ {8{corrupt && flash_addr == 15'h0}};
	assign flash_rdata = flash_req ? {mem[{flash_addr[6:0], 1'b1}], lo}
		: ~{mem[{flash_addr[6:0], 1'b1}], lo};
endmodule : fcs_flash_model

// ### test/testbench.sv
`timescale 1ns/100ps
module testbench;
	typedef struct {
		logic [1:0] region;
		logic corrupt;
		logic exp_ok;
	} fcs_row_t;
	localparam logic [11:0] AC = fcs_pkg::FCS_ADDR_CTRL;
	localparam logic [11:0] AM = fcs_pkg::FCS_ADDR_MODE;
	localparam logic [11:0] AS = fcs_pkg::FCS_ADDR_STAT;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic cpu_sleep, flash_req, cpu_stall, cpu_run, irq_defer, nmi_req;
	logic corrupt;
	logic [14:0] flash_addr;
	logic [15:0] flash_rdata;
	fcs_pkg::fcs_fuse_t fuse;
	int fail_count, checks_done, pulses, gap, cycles, held;
	fcs_row_t rows [4] = '{'{2'h2, 1'b0, 1'b1}, '{2'h1, 1'b0, 1'b1},
		'{2'h2, 1'b1, 1'b0}, '{2'h1, 1'b0, 1'b1}};

	fcs_scanner dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fuse(fuse),
		.cpu_sleep(cpu_sleep), .flash_req(flash_req),
		.flash_addr(flash_addr), .flash_rdata(flash_rdata),
		.cpu_stall(cpu_stall), .cpu_run(cpu_run), .irq_defer(irq_defer),
		.nmi_req(nmi_req));
	fcs_flash_model flash (.flash_req(flash_req),
		.flash_addr(flash_addr), .corrupt(corrupt),
		.flash_rdata(flash_rdata));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wait_idle();
		rd = 32'h1;
		while (rd[0] !== 1'b0)
		begin
			apb(1'b0, AS, 32'h0);
		end
	endtask : wait_idle

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask : do_reset

	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cycles++;
		gap++;
		if (flash_req === 1'b1)
		begin
			if (pulses > 0 && gap < 10)
				check("fetch gap", gap, 3);
			pulses++;
			gap = 0;
		end
		if (cycles == 10000)
		begin
			fail_count++;
			finish_test();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{presetn, psel, penable, pwrite, cpu_sleep, corrupt} = 6'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		fuse = '{scan_en: 1'b0, region: 2'h2, boot_end: 8'h01, app_end: 8'h01};
		do_reset();
		apb(1'b0, AS, 32'h0);
		check("status reset", rd, 32'h2);
		apb(1'b0, 12'h00c, 32'h0);
		check("unmapped", {31'h0, err}, 32'h1);
		foreach (rows[i])
		begin
			apb(1'b1, AM, {30'h0, rows[i].region});
			corrupt <= rows[i].corrupt;
			pulses = 0;
			apb(1'b1, AC, 32'h1);
			repeat (3)
			begin
				@(posedge pclk);
				check("stall in delay", {31'h0, cpu_stall}, 32'h0);
			end
			apb(1'b1, AM, 32'h3);
			check("stall in scan", {31'h0, cpu_stall}, 32'h1);
			wait_idle();
			check("words", pulses, 128);
			check("ok", rd, {30'h0, rows[i].exp_ok, 1'b0});
			apb(1'b0, AM, 32'h0);
			check("busy mode write", rd, {30'h0, rows[i].region});
			apb(1'b0, AC, 32'h0);
			check("enable stays", rd, 32'h1);
			check("nmi quiet", {31'h0, nmi_req}, 32'h0);
		end
		pulses = 0;
		apb(1'b1, AC, 32'h1);
		cpu_sleep <= 1'b1;
		repeat (30) @(posedge pclk);
		check("sleep start", pulses, 0);
		check("defer", {31'h0, irq_defer}, 32'h1);
		cpu_sleep <= 1'b0;
		repeat (60) @(posedge pclk);
		cpu_sleep <= 1'b1;
		repeat (3) @(posedge pclk);
		held = pulses;
		repeat (20) @(posedge pclk);
		check("sleep pause", pulses, held);
		check("stall in sleep", {31'h0, cpu_stall}, 32'h1);
		cpu_sleep <= 1'b0;
		wait_idle();
		check("words after wake", pulses, 128);
		check("defer end", {31'h0, irq_defer}, 32'h0);
		apb(1'b1, AC, 32'h2);
		apb(1'b1, AC, 32'h0);
		apb(1'b0, AC, 32'h0);
		check("irq enable", rd, 32'h3);
		corrupt <= 1'b1;
		apb(1'b1, AC, 32'h3);
		wait_idle();
		check("nmi", {31'h0, nmi_req}, 32'h1);
		apb(1'b1, AC, 32'h80);
		apb(1'b1, AM, 32'h2);
		repeat (5) @(posedge pclk);
		check("nmi held", {31'h0, nmi_req}, 32'h1);
		apb(1'b0, AM, 32'h0);
		check("locked mode", rd, 32'h1);
		for (int c = 1; c >= 0; c--)
		begin
			fuse.scan_en <= 1'b1;
			corrupt <= c[0];
			do_reset();
			check("boot stall", {31'h0, cpu_stall}, 32'h1);
			wait_idle();
			check("boot ok", rd, {30'h0, ~c[0], 1'b0});
			check("boot run", {31'h0, cpu_run}, {31'h0, ~c[0]});
			check("nmi reset", {31'h0, nmi_req}, 32'h0);
			apb(1'b0, AC, 32'h0);
			check("boot enable", rd, 32'h1);
			apb(1'b0, AM, 32'h0);
			check("boot region", rd, 32'h2);
		end
		finish_test();
	end
endmodule : testbench
